/* File: design/branch_group_pkg.sv */
package branch_group_pkg;

  // Opcode bytes handled by this block
  localparam logic [7:0] OP_BRANCH_ZERO = 8'h28;
  localparam logic [7:0] OP_BRANCH_NOT_ZERO = 8'h20;
  localparam logic [7:0] OP_DEC_BRANCH = 8'h10;
  localparam logic [7:0] OP_JUMP_POINTER = 8'hE9;
  localparam logic [7:0] OP_PREFIX_FIRST = 8'hDD;
  localparam logic [7:0] OP_PREFIX_SECOND = 8'hFD;

  // Clock states per machine cycle
  localparam logic [2:0] T_FETCH = 3'h4;
  localparam logic [2:0] T_FETCH_LOOP = 3'h5;
  localparam logic [2:0] T_READ = 3'h3;
  localparam logic [2:0] T_INTERNAL = 3'h5;
  localparam logic [2:0] T_OPCODE_SAMPLE = 3'h3;

  // Reset values
  localparam logic [15:0] PC_RESET = 16'h0000;

  // Register pairs read by the indirect jumps
  typedef struct packed {
    logic [15:0] primary_pointer_pair;
    logic [15:0] first_index_pair;
    logic [15:0] second_index_pair;
  } pointer_pairs_t;

  // Loop count write-back
  typedef struct packed {
    logic wr;
    logic [7:0] value;
  } loop_write_t;

endpackage

/* File: design/branch_group_exec.sv */
// Notes on behaviour
// - Opcode 28h branches by the signed displacement when the zero flag is one.
// - Opcode 20h branches by the signed displacement when the zero flag is zero.
// - A failed zero-flag branch continues after the two-byte instruction.
// - Targets reckon from the opcode address, reaching -126 to +129 bytes.
// - Displacement byte is added after the counter has passed both bytes.
// - Taken zero-flag branch lasts twelve states: four, three, five.
// - Untaken zero-flag branch lasts seven states: four and three.
// - Opcode E9h loads the primary pointer pair into the counter in four states.
// - DDh then E9h loads the first index pair, eight states, four and four.
// - FDh then E9h loads the second index pair with the same timing.
// - Opcode 10h decrements the loop count and branches if it stays nonzero.
// - When the loop count reaches zero, execution continues after the instruction.
// - Loop branch lasts thirteen states taken, eight states not taken.
// - No instruction of this group writes any condition flag.
// - After a taken branch or jump the next fetch uses the new counter.
`timescale 1ns/10ps
`default_nettype none
module branch_group_exec (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [7:0] mem_data,
  input wire logic zero_flag,
  input wire logic [7:0] loop_count,
  input wire branch_group_pkg::pointer_pairs_t pairs,
  output logic [15:0] mem_addr,
  output logic mem_rd,
  output logic [15:0] pc,
  output branch_group_pkg::loop_write_t loop_write,
  output logic flag_wr,
  output logic instr_done,
  output logic unknown_op
);
  import branch_group_pkg::*;

  typedef enum logic [3:0] {
    ST_FETCH = 4'b0001,
    ST_PREFIX = 4'b0010,
    ST_DISP = 4'b0100,
    ST_INTERNAL = 4'b1000
  } state_t;

  state_t state;
  logic [2:0] tcnt;
  logic [7:0] op;
  logic [7:0] prefix;
  logic [7:0] disp;
  logic taken;
  logic [15:0] op_pc;

  // ==========================================================
  // Decode
  // ==========================================================
  // The opcode is live on the bus in the sampling state, so decode looks through
  // the register there; a loop opcode stretches its own fetch by one state.
  wire [7:0] cur_op = (tcnt == T_OPCODE_SAMPLE) ? mem_data : op;
  wire [2:0] fetch_len = (cur_op == OP_DEC_BRANCH) ? T_FETCH_LOOP : T_FETCH;
  wire [2:0] cyc_len = (state == ST_FETCH) ? fetch_len :
                       (state == ST_PREFIX) ? T_FETCH :
                       (state == ST_DISP) ? T_READ : T_INTERNAL;
  wire last = (tcnt == cyc_len - 3'h1);
  wire [7:0] loop_dec = loop_count - 8'h01;
  wire is_rel = (cur_op == OP_BRANCH_ZERO) || (cur_op == OP_BRANCH_NOT_ZERO);
  wire is_loop = (cur_op == OP_DEC_BRANCH);
  wire is_prefix = (cur_op == OP_PREFIX_FIRST) || (cur_op == OP_PREFIX_SECOND);
  wire cond_taken = ((cur_op == OP_BRANCH_ZERO) && zero_flag) ||
                    ((cur_op == OP_BRANCH_NOT_ZERO) && !zero_flag) ||
                    (is_loop && (loop_dec != 8'h00));
  wire [15:0] pc_inc = pc + 16'h0001;
  wire [15:0] disp_ext = {{8{disp[7]}}, disp};
  wire [15:0] rel_target = pc + disp_ext;
  wire [15:0] index_sel = (prefix == OP_PREFIX_FIRST) ? pairs.first_index_pair :
                          pairs.second_index_pair;
  wire fetch_end = (state == ST_FETCH) && last;
  wire prefix_end = (state == ST_PREFIX) && last;
  wire disp_end = (state == ST_DISP) && last;
  wire internal_end = (state == ST_INTERNAL) && last;
  wire fetch_unknown = fetch_end && !is_rel && !is_loop && !is_prefix &&
                       (cur_op != OP_JUMP_POINTER);
  wire prefix_unknown = prefix_end && (mem_data != OP_JUMP_POINTER);
  // Unsupported opcodes are skipped as one byte, or as two after a prefix, so the block never hangs
  wire next_done = (fetch_end && !is_rel && !is_loop && !is_prefix) ||
                   prefix_end || (disp_end && !taken) || internal_end;

  // ==========================================================
  // Bus and side outputs
  // ==========================================================
  // Every fetch addresses the counter straight from its flop
  assign mem_addr = pc;
  assign mem_rd = (state != ST_INTERNAL);
  // Nothing in this group owns a flag write path
  assign flag_wr = 1'b0;

  // ==========================================================
  // Sequencer
  // ==========================================================
  // One state per clock; the counter moves at the last state of each machine cycle.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      state <= ST_FETCH;
      tcnt <= 3'h0;
      op <= 8'h00;
      prefix <= 8'h00;
      disp <= 8'h00;
      taken <= 1'b0;
      pc <= PC_RESET;
      op_pc <= PC_RESET;
      loop_write <= '0;
      instr_done <= 1'b0;
      unknown_op <= 1'b0;
    end else begin
      tcnt <= last ? 3'h0 : tcnt + 3'h1;
      instr_done <= next_done;
      unknown_op <= fetch_unknown || prefix_unknown;
      loop_write.wr <= fetch_end && is_loop;
      loop_write.value <= loop_dec;
      if (state == ST_FETCH && tcnt == 3'h0) begin
        op_pc <= pc;
      end
      if (tcnt == T_OPCODE_SAMPLE && state == ST_FETCH) begin
        op <= mem_data;
      end
      unique case (state)
        ST_FETCH: begin
          if (last) begin
            taken <= cond_taken;
            if (cur_op == OP_JUMP_POINTER) begin
              pc <= pairs.primary_pointer_pair;
            end else begin
              pc <= pc_inc;
            end
            if (is_prefix) begin
              prefix <= cur_op;
              state <= ST_PREFIX;
            end else if (is_rel || is_loop) begin
              state <= ST_DISP;
            end
          end
        end
        ST_PREFIX: begin
          if (last) begin
            pc <= (mem_data == OP_JUMP_POINTER) ? index_sel : pc_inc;
            state <= ST_FETCH;
          end
        end
        ST_DISP: begin
          if (last) begin
            disp <= mem_data;
            pc <= pc_inc;
            state <= taken ? ST_INTERNAL : ST_FETCH;
          end
        end
        ST_INTERNAL: begin
          if (last) begin
            pc <= rel_target;
            state <= ST_FETCH;
          end
        end
      endcase
    end
  end

  // ==========================================================
  // Checks
  // ==========================================================
  // Length of the instruction that ended, valid in the cycle instr_done is high
  logic [4:0] ilen;
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      ilen <= 5'h00;
    end else begin
      ilen <= instr_done ? 5'h01 : ilen + 5'h01;
    end
  end

  AST_TAKEN_REL_LEN: assert property (@(posedge mclk) disable iff (sys_rst)
    instr_done && taken && (op == OP_BRANCH_ZERO || op == OP_BRANCH_NOT_ZERO) |-> ilen == 5'd12)
    else $error("taken relative branch not twelve states");
  AST_UNTAKEN_REL_LEN: assert property (@(posedge mclk) disable iff (sys_rst)
    instr_done && !taken && (op == OP_BRANCH_ZERO || op == OP_BRANCH_NOT_ZERO) |-> ilen == 5'd7)
    else $error("untaken relative branch not seven states");
  AST_LOOP_LEN: assert property (@(posedge mclk) disable iff (sys_rst)
    instr_done && op == OP_DEC_BRANCH |-> ilen == (taken ? 5'd13 : 5'd8))
    else $error("loop branch length wrong");
  AST_POINTER_JUMP: assert property (@(posedge mclk) disable iff (sys_rst)
    instr_done && op == OP_JUMP_POINTER |-> ilen == 5'd4 && pc == $past(pairs.primary_pointer_pair))
    else $error("pointer jump wrong target or length");
  AST_INDEX_JUMP: assert property (@(posedge mclk) disable iff (sys_rst)
    prefix_end && mem_data == OP_JUMP_POINTER |=> pc == $past(index_sel) && instr_done && ilen == 5'd8)
    else $error("index jump wrong target or length");
  AST_REL_TARGET: assert property (@(posedge mclk) disable iff (sys_rst)
    instr_done && taken && op != OP_JUMP_POINTER |-> pc == op_pc + 16'h0002 + disp_ext)
    else $error("branch target not opcode address plus two plus displacement");
  AST_FALL_THROUGH: assert property (@(posedge mclk) disable iff (sys_rst)
    instr_done && !taken && (op == OP_BRANCH_ZERO || op == OP_BRANCH_NOT_ZERO ||
    op == OP_DEC_BRANCH) |-> pc == op_pc + 16'h0002)
    else $error("untaken branch did not skip two bytes");
  AST_Z_TAKEN: assert property (@(posedge mclk) disable iff (sys_rst)
    fetch_end && cur_op == OP_BRANCH_ZERO |=> taken == $past(zero_flag))
    else $error("zero branch decision wrong");
  AST_LOOP_WRITE: assert property (@(posedge mclk) disable iff (sys_rst)
    fetch_end && is_loop |=> loop_write.wr && loop_write.value == $past(loop_count) - 8'h01 ##1 !loop_write.wr)
    else $error("loop count write wrong");
  AST_FETCH_ADDR: assert property (@(posedge mclk) disable iff (sys_rst)
    instr_done |-> mem_rd && mem_addr == pc && state == ST_FETCH && tcnt == 3'h0)
    else $error("next fetch not at updated counter");
  AST_NO_FLAGS: assert property (@(posedge mclk) disable iff (sys_rst)
    instr_done |-> !flag_wr && !$past(flag_wr))
    else $error("flag write seen");
endmodule
`default_nettype wire

/* File: sim/prog_mem.sv */
`timescale 1ns/10ps
`default_nettype none
module prog_mem (
  input wire logic mclk,
  input wire logic mem_rd,
  input wire logic [15:0] mem_addr,
  output logic [7:0] mem_data
);
  // ==========
  // Storage
  logic [7:0] mem [0:65535];
  logic [7:0] last;
  // Unused bytes read as an unsupported opcode, never as unknown
  initial begin
    for (int i = 0; i < 65536; i++) mem[i] = 8'h00;
  end
  // Remember the last byte shown so an idle bus can show its inverse
  always_ff @(posedge mclk) begin
    if (mem_rd) last <= mem[mem_addr];
  end
  // Idle bus flips so a stale byte is never mistaken for fresh data
  assign mem_data = mem_rd ? mem[mem_addr] : ~last;
endmodule
`default_nettype wire

/* File: sim/cpu_branch_group_exec_tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
module cpu_branch_group_exec_tb_top;
  import branch_group_pkg::*;
  // ==========
  // Signals and instances
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic zero_flag = 1'b0;
  logic [7:0] loop_count = 8'h00;
  pointer_pairs_t pairs = '0;
  logic [7:0] mem_data;
  logic [15:0] mem_addr;
  logic [15:0] pc;
  logic mem_rd, flag_wr, instr_done, unknown_op;
  loop_write_t loop_write;
  int n_fail = 0;
  int tests_run = 0;
  branch_group_exec i_branch_group_exec (.mclk(mclk), .sys_rst(sys_rst), .mem_data(mem_data),
    .zero_flag(zero_flag), .loop_count(loop_count), .pairs(pairs), .mem_addr(mem_addr),
    .mem_rd(mem_rd), .pc(pc), .loop_write(loop_write), .flag_wr(flag_wr),
    .instr_done(instr_done), .unknown_op(unknown_op));
  prog_mem i_prog_mem (.mclk(mclk), .mem_rd(mem_rd), .mem_addr(mem_addr), .mem_data(mem_data));
  // 200 MHz clock
  initial begin
    forever #2.5 mclk = ~mclk;
  end
  // ==========
  // Shared tasks
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic put(input logic [15:0] a, input logic [7:0] b0, input logic [7:0] b1);
    i_prog_mem.mem[a] = b0;
    i_prog_mem.mem[a + 16'h0001] = b1;
  endtask
  // Runs one instruction to its completion pulse; a zero length skips timing
  task automatic step(input logic [15:0] exp_pc, input int exp_len, input logic [8:0] exp_loop);
    int n;
    int idle;
    int bad;
    logic [8:0] got;
    n = 0;
    idle = 0;
    bad = 0;
    got = 9'h000;
    do begin
      @(posedge mclk);
      #1;
      n++;
      if (mem_rd === 1'b0) idle++;
      if (flag_wr !== 1'b0) bad++;
      if (loop_write.wr === 1'b1) got = loop_write;
    end while (instr_done !== 1'b1 && n < 40);
    check("pc", pc, exp_pc);
    check("fetch address", mem_addr, exp_pc);
    check("flag writes", 16'(bad), 16'h0000);
    check("loop write", 16'(got), 16'(exp_loop));
    if (exp_len != 0) begin
      check("length", 16'(n), 16'(exp_len));
      check("idle states", 16'(idle), (exp_len > 11) ? 16'h0005 : 16'h0000);
    end
  endtask
  // ==========
  // Scenarios
  task automatic test_reset;
    pairs.primary_pointer_pair = 16'h0100;
    repeat (20) @(posedge mclk);
    #1;
    // Loaded after time zero so the memory's own clearing cannot overwrite it
    put(16'h0000, OP_JUMP_POINTER, 8'h00);
    check("reset pc", pc, PC_RESET);
    check("reset read", {15'h0000, mem_rd}, 16'h0001);
    sys_rst = 1'b0;
    step(16'h0100, 0, 9'h000);
  endtask
  task automatic test_branch_zero;
    put(16'h0100, OP_BRANCH_ZERO, 8'h7F);
    zero_flag = 1'b1;
    step(16'h0181, 12, 9'h000);
    put(16'h0181, OP_BRANCH_ZERO, 8'h00);
    zero_flag = 1'b0;
    step(16'h0183, 7, 9'h000);
  endtask
  task automatic test_branch_not_zero;
    put(16'h0183, OP_BRANCH_NOT_ZERO, 8'h80);
    step(16'h0105, 12, 9'h000);
    put(16'h0105, OP_BRANCH_NOT_ZERO, 8'h05);
    zero_flag = 1'b1;
    step(16'h0107, 7, 9'h000);
  endtask
  task automatic test_index_jumps;
    put(16'h0107, OP_PREFIX_FIRST, OP_JUMP_POINTER);
    pairs.first_index_pair = 16'h2000;
    step(16'h2000, 8, 9'h000);
    put(16'h2000, OP_PREFIX_SECOND, OP_JUMP_POINTER);
    pairs.second_index_pair = 16'h3000;
    step(16'h3000, 8, 9'h000);
  endtask
  task automatic test_jump_pointer;
    put(16'h3000, OP_JUMP_POINTER, 8'h00);
    pairs.primary_pointer_pair = 16'h4000;
    step(16'h4000, 4, 9'h000);
  endtask
  // Count 00h wraps to FFh and must still branch
  task automatic test_loop;
    put(16'h4000, OP_DEC_BRANCH, 8'hFE);
    put(16'h4002, OP_DEC_BRANCH, 8'hFE);
    loop_count = 8'h02;
    step(16'h4000, 13, 9'h101);
    loop_count = 8'h01;
    step(16'h4002, 8, 9'h100);
    loop_count = 8'h00;
    step(16'h4002, 13, 9'h1FF);
  endtask
  // Plain unsupported byte skips one, a prefix with a foreign second byte skips two
  task automatic test_unknown;
    put(16'h4002, 8'h00, 8'h00);
    step(16'h4003, 4, 9'h000);
    check("unknown op", {15'h0000, unknown_op}, 16'h0001);
    put(16'h4003, OP_PREFIX_FIRST, 8'h00);
    step(16'h4005, 8, 9'h000);
    check("unknown prefix op", {15'h0000, unknown_op}, 16'h0001);
  endtask
  // ==========
  // Verdict, sequence and watchdog
  task automatic print_verdict;
    $display("Checks run %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    test_reset;
    test_branch_zero;
    test_branch_not_zero;
    test_index_jumps;
    test_jump_pointer;
    test_loop;
    test_unknown;
    print_verdict;
  end
  // Whole run needs about 130 cycles; this leaves wide margin
  initial begin
    #20000;
    n_fail++;
    print_verdict;
  end
endmodule
`default_nettype wire
